// file: src/trp_prbs.v
// Pseudo-random bit generator, one instance per sequence length
`timescale 1ns/10ps
`default_nettype none

module trp_prbs #(
    parameter LEN = 9,
    parameter TAP = 5
) (
    input  wire clock,
    input  wire resetn,
    input  wire enable,
    input  wire advance,
    output wire bitOut
);

    reg [LEN-1:0] lfsr_q;

    // Restart from the all-ones seed whenever the mode is off, so every
    // run emits the sequence from its beginning
    always @(posedge clock) begin
        if (!resetn || !enable) begin
            lfsr_q <= {LEN{1'b1}};
        end else if (advance) begin
            lfsr_q <= {lfsr_q[LEN-2:0], lfsr_q[LEN-1] ^ lfsr_q[TAP-1]};
        end
    end

    assign bitOut = lfsr_q[LEN-1];

endmodule // trp_prbs

`default_nettype wire

// file: src/trp_regs.vh
// Register map, field positions and reset values of the timer reload and test page block
`ifndef TRP_REGS_VH
`define TRP_REGS_VH

// Printed register indices; the APB byte address is four times the index
`define TRP_IDX_RELOAD_HI    6'h2c
`define TRP_IDX_RELOAD_LO    6'h2d
`define TRP_IDX_COUNT_HI     6'h2e
`define TRP_IDX_COUNT_LO     6'h2f
`define TRP_IDX_PAGE         6'h30
`define TRP_IDX_TEST_ONE     6'h31
`define TRP_IDX_TEST_TWO     6'h32
`define TRP_BYTE_LANE        2'h0

// Reset values
`define TRP_RST_BYTE         8'h00
`define TRP_RST_COUNT        16'h0000
`define TRP_RST_ADDR         6'h00

// Page register fields
`define TRP_PAGE_EN_BIT      7
`define TRP_PAGE_FLD_HI      1
`define TRP_PAGE_FLD_LO      0

// Test select one fields
`define TRP_SAM_SRC_HI       5
`define TRP_SAM_SRC_LO       4
`define TRP_CLK_PIN_BIT      3
`define TRP_BIT_SEL_HI       2
`define TRP_BIT_SEL_LO       0

// Secure-module clock source codes
`define TRP_SAM_OFF          2'h0
`define TRP_SAM_OSC          2'h1
`define TRP_SAM_UART         2'h2
`define TRP_SAM_RF           2'h3

// Test select two fields
`define TRP_FLIP_BIT         7
`define TRP_PRBS9_BIT        6
`define TRP_PRBS15_BIT       5
`define TRP_GROUP_HI         4
`define TRP_GROUP_LO         0

// Parallel port line that carries the secure-module clock
`define TRP_D1_LINE          1

// Pseudo-random generator shapes
`define TRP_PRBS9_LEN        9
`define TRP_PRBS9_TAP        5
`define TRP_PRBS15_LEN       15
`define TRP_PRBS15_TAP       14

`endif

// file: src/trp_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module trp_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             resetn,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;

    // First stage is read only by the second stage
    always @(posedge clock) begin
        if (!resetn) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;

endmodule // trp_sync

`default_nettype wire

// file: src/trp_top.v
// Timer reload/count, register page and test select registers on APB
//
// Functional notes
// - Reload value held in two byte registers
// - Start event copies reload into counter
// - Reload writes never disturb a running count
// - Current count readable as two bytes
// - Page enable drives address bits five, four
// - Low address bits from pins or latch
// - Page disabled: whole address from latch
// - Page field ignored unless page enabled
// - Secure clock source: off, osc, uart, rf
// - Clock-to-pin bit drives secure clock on D1
// - Bit select picks probe bit for signal output
// - Flip bit maps probe bus onto port lines
// - Bit six enables PRBS9 sequence mode
// - Bit five enables PRBS15 sequence mode
// - Sequence starts only on transmit command
// - Five-bit field selects observed probe group
// - Without auto reload, stop at zero, flag
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "trp_regs.vh"

module trp_top (
    input  wire        clock,
    input  wire        resetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Timer control from the surrounding timer unit
    input  wire        timerStart,
    input  wire        timerTick,
    input  wire        timerAutoReload,
    input  wire        timerIrqClear,
    output wire        timerIrqFlag,
    output wire        timerRunning,
    // Register address formation
    input  wire [5:0]  hostAddrPins,
    input  wire [5:0]  addrLatch,
    input  wire        useAddrPins,
    output wire [5:0]  regAddress,
    // Secure-module clock sources (pins, asynchronous)
    input  wire        oscClock,
    input  wire        uartClock,
    input  wire        rfClock,
    output wire        samClock,
    // Probe bus and its outputs
    input  wire [7:0]  probeBus,
    output wire [4:0]  probeGroupSelect,
    output wire        serialSignalOutput,
    output wire [6:0]  parPortOut,
    output wire [6:0]  parPortOe,
    // Transmitter pseudo-random sequence
    input  wire        txCommand,
    input  wire        txBitStrobe,
    output wire        prbsActive,
    output wire        prbsData
);

    // Software-visible registers
    reg [7:0]  reloadUpperByte_q;
    reg [7:0]  reloadLowerByte_q;
    reg [15:0] timerCount_q;
    reg        pageEnable_q;
    reg [1:0]  pageField_q;
    reg [7:0]  testSelOne_q;
    reg [7:0]  testSelTwo_q;

    // Timer state
    reg        timerRun_q;
    reg        timer_irq_flag_q;

    // APB answer registers
    reg [31:0] prdata_q;
    reg        pready_q;
    reg        pslverr_q;

    // Pin-facing and test outputs
    reg [5:0]  regAddress_q;
    reg        samClock_q;
    reg        serialOut_q;
    reg [6:0]  parPortOut_q;
    reg [6:0]  parPortOe_q;
    reg        prbsActive_q;
    reg        prbsData_q;

    // Decoded access
    reg [7:0]  readByte;
    reg        addrHit;

    wire [15:0] timerReloadValue;
    wire        apbAccess;
    wire        apbWrite;
    wire [5:0]  regIndex;
    wire        laneOk;
    wire [5:0]  syncAddrPins;
    wire [2:0]  syncClocks;
    wire        prbs9Enable;
    wire        prbs15Enable;
    wire        prbs9Bit;
    wire        prbs15Bit;
    wire [1:0]  samSource;
    wire [2:0]  probeBitSelect;
    wire        clockToPinEnable;
    wire        probePortFlip;
    wire        timerHitsZero;

    assign timerReloadValue = {reloadUpperByte_q, reloadLowerByte_q};
    assign regIndex         = paddr[7:2];
    assign laneOk           = (paddr[1:0] == `TRP_BYTE_LANE);
    assign apbAccess        = psel & penable & pready_q;
    assign apbWrite         = apbAccess & pwrite & addrHit;
    assign samSource        = testSelOne_q[`TRP_SAM_SRC_HI:`TRP_SAM_SRC_LO];
    assign probeBitSelect   = testSelOne_q[`TRP_BIT_SEL_HI:`TRP_BIT_SEL_LO];
    assign clockToPinEnable = testSelOne_q[`TRP_CLK_PIN_BIT];
    assign probePortFlip    = testSelTwo_q[`TRP_FLIP_BIT];
    assign prbs9Enable      = testSelTwo_q[`TRP_PRBS9_BIT];
    assign prbs15Enable     = testSelTwo_q[`TRP_PRBS15_BIT];
    assign timerHitsZero    = timerRun_q & timerTick &
                              (timerCount_q == 16'h0001);

    // Address pins come from outside the clock domain
    trp_sync #(
        .WIDTH (6)
    ) u_addr_sync (
        .clock   (clock),
        .resetn  (resetn),
        .asyncIn (hostAddrPins),
        .syncOut (syncAddrPins)
    );

    // Clock sources are sampled as levels; 200 MHz oversamples them
    trp_sync #(
        .WIDTH (3)
    ) u_clk_sync (
        .clock   (clock),
        .resetn  (resetn),
        .asyncIn ({rfClock, uartClock, oscClock}),
        .syncOut (syncClocks)
    );

    // Address decode and read mux; the page register's reserved bits
    // are never stored, so they read back as zero
    always @* begin
        addrHit  = laneOk;
        readByte = 8'h00;
        if (regIndex == `TRP_IDX_RELOAD_HI) begin
            readByte = reloadUpperByte_q;
        end else if (regIndex == `TRP_IDX_RELOAD_LO) begin
            readByte = reloadLowerByte_q;
        end else if (regIndex == `TRP_IDX_COUNT_HI) begin
            readByte = timerCount_q[15:8];
        end else if (regIndex == `TRP_IDX_COUNT_LO) begin
            readByte = timerCount_q[7:0];
        end else if (regIndex == `TRP_IDX_PAGE) begin
            readByte = {pageEnable_q, 5'h00, pageField_q};
        end else if (regIndex == `TRP_IDX_TEST_ONE) begin
            readByte = testSelOne_q;
        end else if (regIndex == `TRP_IDX_TEST_TWO) begin
            readByte = testSelTwo_q;
        end else begin
            addrHit = 1'b0;
        end
    end

    // One wait state: pready rises in the second access cycle, which
    // lets read data come from a flip-flop
    always @(posedge clock) begin
        if (!resetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~addrHit;
            prdata_q  <= (addrHit && !pwrite) ? {24'h000000, readByte}
                                               : 32'h00000000;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Register writes; count registers are read-only and ignore writes
    always @(posedge clock) begin
        if (!resetn) begin
            reloadUpperByte_q <= `TRP_RST_BYTE;
            reloadLowerByte_q <= `TRP_RST_BYTE;
            pageEnable_q      <= 1'b0;
            pageField_q       <= 2'h0;
            testSelOne_q      <= `TRP_RST_BYTE;
            testSelTwo_q      <= `TRP_RST_BYTE;
        end else if (apbWrite) begin
            if (regIndex == `TRP_IDX_RELOAD_HI) begin
                reloadUpperByte_q <= pwdata[7:0];
            end else if (regIndex == `TRP_IDX_RELOAD_LO) begin
                reloadLowerByte_q <= pwdata[7:0];
            end else if (regIndex == `TRP_IDX_PAGE) begin
                pageEnable_q <= pwdata[`TRP_PAGE_EN_BIT];
                pageField_q  <= pwdata[`TRP_PAGE_FLD_HI:`TRP_PAGE_FLD_LO];
            end else if (regIndex == `TRP_IDX_TEST_ONE) begin
                testSelOne_q <= pwdata[7:0];
            end else if (regIndex == `TRP_IDX_TEST_TWO) begin
                testSelTwo_q <= pwdata[7:0];
            end
        end
    end

    // Timer counter: a start event loads the reload value; the reload
    // registers are read only here, so writes never touch a live count
    always @(posedge clock) begin
        if (!resetn) begin
            timerCount_q <= `TRP_RST_COUNT;
            timerRun_q   <= 1'b0;
        end else if (timerStart) begin
            timerCount_q <= timerReloadValue;
            timerRun_q   <= 1'b1;
        end else if (timerRun_q && timerTick) begin
            if (timerCount_q == 16'h0000) begin
                if (timerAutoReload) begin
                    timerCount_q <= timerReloadValue;
                end else begin
                    timerRun_q <= 1'b0;
                end
            end else begin
                timerCount_q <= timerCount_q - 16'h0001;
                if (timerCount_q == 16'h0001 && !timerAutoReload) begin
                    timerRun_q <= 1'b0;
                end
            end
        end
    end

    // Interrupt request flag: a zero hit in the clearing cycle wins
    always @(posedge clock) begin
        if (!resetn) begin
            timer_irq_flag_q <= 1'b0;
        end else if (timerHitsZero && !timerAutoReload) begin
            timer_irq_flag_q <= 1'b1;
        end else if (timerIrqClear) begin
            timer_irq_flag_q <= 1'b0;
        end
    end

    // Register address formation
    always @(posedge clock) begin
        if (!resetn) begin
            regAddress_q <= `TRP_RST_ADDR;
        end else if (pageEnable_q) begin
            regAddress_q[5:4] <= pageField_q;
            regAddress_q[3:0] <= useAddrPins ? syncAddrPins[3:0]
                                             : addrLatch[3:0];
        end else begin
            regAddress_q <= addrLatch;
        end
    end

    // Secure-module clock source mux
    always @(posedge clock) begin
        if (!resetn) begin
            samClock_q <= 1'b0;
        end else begin
            case (samSource)
                `TRP_SAM_OFF:  samClock_q <= 1'b0;
                `TRP_SAM_OSC:  samClock_q <= syncClocks[0];
                `TRP_SAM_UART: samClock_q <= syncClocks[1];
                default:       samClock_q <= syncClocks[2];
            endcase
        end
    end

    // Probe bit onto the serial signal output
    always @(posedge clock) begin
        if (!resetn) begin
            serialOut_q <= 1'b0;
        end else begin
            serialOut_q <= probeBus[probeBitSelect];
        end
    end

    // Parallel port: flip maps probe bits 0..6 to D4,D3,D2,D6,D5,D0,D1;
    // the secure clock on D1 overrides the probe bit there. The host must
    // keep the clock off D1 while the parallel bus is in use
    always @(posedge clock) begin
        if (!resetn) begin
            parPortOut_q <= 7'h00;
            parPortOe_q  <= 7'h00;
        end else begin
            if (probePortFlip) begin
                parPortOut_q <= {probeBus[3], probeBus[4], probeBus[0],
                                 probeBus[1], probeBus[2], probeBus[6],
                                 probeBus[5]};
                parPortOe_q  <= 7'h7f;
            end else begin
                parPortOut_q <= 7'h00;
                parPortOe_q  <= 7'h00;
            end
            if (clockToPinEnable) begin
                parPortOut_q[`TRP_D1_LINE] <= samClock_q;
                parPortOe_q[`TRP_D1_LINE]  <= 1'b1;
            end
        end
    end

    // Sequence generators, held at the seed until the mode is on
    trp_prbs #(
        .LEN (`TRP_PRBS9_LEN),
        .TAP (`TRP_PRBS9_TAP)
    ) u_prbs9 (
        .clock   (clock),
        .resetn  (resetn),
        .enable  (prbs9Enable),
        .advance (prbsActive_q & txBitStrobe),
        .bitOut  (prbs9Bit)
    );

    trp_prbs #(
        .LEN (`TRP_PRBS15_LEN),
        .TAP (`TRP_PRBS15_TAP)
    ) u_prbs15 (
        .clock   (clock),
        .resetn  (resetn),
        .enable  (prbs15Enable),
        .advance (prbsActive_q & txBitStrobe),
        .bitOut  (prbs15Bit)
    );

    // Sending begins only on the transmit command and ends with the mode;
    // the transmitter setup is the host's job beforehand
    always @(posedge clock) begin
        if (!resetn) begin
            prbsActive_q <= 1'b0;
            prbsData_q   <= 1'b0;
        end else begin
            if (!prbs9Enable && !prbs15Enable) begin
                prbsActive_q <= 1'b0;
            end else if (txCommand) begin
                prbsActive_q <= 1'b1;
            end
            prbsData_q <= prbs9Enable ? prbs9Bit : prbs15Bit;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign timerIrqFlag       = timer_irq_flag_q;
    assign timerRunning       = timerRun_q;
    assign regAddress         = regAddress_q;
    assign samClock           = samClock_q;
    assign probeGroupSelect   = testSelTwo_q[`TRP_GROUP_HI:`TRP_GROUP_LO];
    assign serialSignalOutput = serialOut_q;
    assign parPortOut         = parPortOut_q;
    assign parPortOe          = parPortOe_q;
    assign prbsActive         = prbsActive_q;
    assign prbsData           = prbsData_q;

endmodule // trp_top

`default_nettype wire

// file: verif/tb_timer_reload_and_test_page_regs.sv
// Testbench for the timer reload and test page register slice
`timescale 1ns/10ps
`default_nettype none

module tb_timer_reload_and_test_page_regs;
    logic        clock, resetn, slowClk;
    logic        timerStart, timerTick, timerAutoReload, timerIrqClear;
    logic        useAddrPins, txCommand, txBitStrobe;
    logic [5:0]  hostAddrPins, addrLatch;
    logic [7:0]  probeBus;
    logic [2:0]  srcEn;
    wire  logic  psel, penable, pwrite, pready, pslverr, timerIrqFlag;
    wire  logic  timerRunning, samClock, serialSignalOutput;
    wire  logic  prbsActive, prbsData;
    wire  logic [7:0]  paddr;
    wire  logic [31:0] pwdata, prdata;
    wire  logic [5:0]  regAddress;
    wire  logic [4:0]  probeGroupSelect;
    wire  logic [6:0]  parPortOut, parPortOe;
    wire  logic  oscClock = slowClk & srcEn[0];
    wire  logic  uartClock = slowClk & srcEn[1];
    wire  logic  rfClock = slowClk & srcEn[2];
    int          error_cnt, total_checks;

    trp_top dut (.*);
    trp_host_model host (.*);

    // Main clock and an unrelated slow source clock
    always #2.5 clock = ~clock;
    always #15 slowClk = ~slowClk;

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bus access; a hung slave ends the run
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] wd, output logic [8:0] r);
        logic t;
        host.xfer(w, a, wd, r[7:0], r[8], t);
        if (t) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        bus(1'b1, a, d, r);
        cmp(32'(r[8]), 32'h0);
    endtask

    // Read compare: expected {error, data}
    task automatic rdc(input logic [7:0] a, input logic [8:0] exp);
        logic [8:0] r;
        bus(1'b0, a, 8'h00, r);
        cmp(32'(r), 32'(exp));
    endtask

    task automatic s_regs();
        for (int a = 'hb0; a <= 'hc8; a += 4)
            rdc(8'(a), 9'h000);
        rdc(8'hd0, 9'h100);
        rdc(8'hb1, 9'h100);
        wr(8'hb0, 8'ha5);
        wr(8'hb4, 8'h3c);
        rdc(8'hb0, 9'h0a5);
        rdc(8'hb4, 9'h03c);
        wr(8'hbc, 8'hff);
        rdc(8'hbc, 9'h000);
        wr(8'hc0, 8'h7e);
        rdc(8'hc0, 9'h002);
    endtask

    task automatic s_timer();
        wr(8'hb0, 8'h01);
        wr(8'hb4, 8'h03);
        timerStart <= 1'b1;
        @(posedge clock);
        timerStart <= 1'b0;
        rdc(8'hb8, 9'h001);
        wr(8'hb4, 8'h09);
        rdc(8'hbc, 9'h003);
        cmp(32'(timerRunning), 32'h1);
        timerTick <= 1'b1;
        cyc(258);
        cmp(32'(timerIrqFlag), 32'h0);
        cyc(1);
        timerTick <= 1'b0;
        cyc(2);
        cmp(32'({timerIrqFlag, timerRunning}), 32'h2);
        rdc(8'hbc, 9'h000);
        timerIrqClear <= 1'b1;
        @(posedge clock);
        timerIrqClear <= 1'b0;
        cyc(1);
        cmp(32'(timerIrqFlag), 32'h0);
        timerStart <= 1'b1;
        @(posedge clock);
        timerStart <= 1'b0;
        rdc(8'hbc, 9'h009);
        // Auto reload: 2,1,0 then reload 2,1 after four ticks, no flag
        wr(8'hb0, 8'h00);
        wr(8'hb4, 8'h02);
        timerAutoReload <= 1'b1;
        timerStart <= 1'b1;
        @(posedge clock);
        timerStart <= 1'b0;
        timerTick <= 1'b1;
        cyc(4);
        timerTick <= 1'b0;
        rdc(8'hbc, 9'h001);
        cmp(32'({timerIrqFlag, timerRunning}), 32'h1);
        timerAutoReload <= 1'b0;
    endtask

    task automatic s_page();
        cyc(4);
        cmp(32'(regAddress), 32'h15);
        wr(8'hc0, 8'h82);
        cyc(6);
        cmp(32'(regAddress), 32'h25);
        useAddrPins <= 1'b1;
        cyc(6);
        cmp(32'(regAddress), 32'h2c);
        wr(8'hc0, 8'h00);
    endtask

    // No parallel host bus here, so line one may carry the clock
    task automatic s_test_one();
        int n, p;
        probeBus <= 8'h96;
        for (int i = 0; i < 8; i++) begin
            wr(8'hc4, 8'(i));
            cyc(3);
            cmp(32'(serialSignalOutput), 32'((8'h96 >> i) & 8'h01));
        end
        for (int s = 0; s < 4; s++) begin
            srcEn <= (s == 0) ? 3'h7 : 3'(1 << (s - 1));
            wr(8'hc4, 8'(s * 16 + 8));
            n = 0;
            p = 0;
            repeat (40) begin
                @(posedge clock);
                n += samClock;
                p += parPortOut[1];
            end
            cmp(32'(n > 0), 32'(s != 0));
            cmp(32'({p > 0, parPortOe[1]}), 32'({s != 0, 1'b1}));
        end
        wr(8'hc4, 8'h00);
    endtask

    task automatic s_flip();
        logic [7:0] v;
        wr(8'hc8, 8'h80);
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h0f : 8'h5a;
            probeBus <= v;
            cyc(3);
            cmp(32'(parPortOut), 32'({v[3], v[4], v[0], v[1], v[2], v[6],
                                      v[5]}));
            cmp(32'(parPortOe), 32'h7f);
        end
        wr(8'hc8, 8'h00);
    endtask

    // Full period of each sequence; maximal sequences hold (len+1)/2 ones
    task automatic s_prbs();
        int len, ones;
        txCommand <= 1'b1;
        @(posedge clock);
        txCommand <= 1'b0;
        cyc(2);
        cmp(32'(prbsActive), 32'h0);
        for (int m = 0; m < 2; m++) begin
            len = m ? 32767 : 511;
            wr(8'hc8, m ? 8'h33 : 8'h53);
            cyc(3);
            cmp(32'({probeGroupSelect, prbsActive}), 32'h26);
            txCommand <= 1'b1;
            @(posedge clock);
            txCommand <= 1'b0;
            cyc(2);
            cmp(32'(prbsActive), 32'h1);
            txBitStrobe <= 1'b1;
            cyc(2);
            ones = 0;
            repeat (len) begin
                @(posedge clock);
                ones += prbsData;
            end
            txBitStrobe <= 1'b0;
            cmp(32'(ones), 32'((len + 1) / 2));
            wr(8'hc8, 8'h00);
            cyc(2);
            cmp(32'(prbsActive), 32'h0);
        end
    endtask

    // Reset for twelve cycles, then every scenario in turn
    initial begin
        clock = 1'b0;
        slowClk = 1'b0;
        resetn = 1'b0;
        timerStart = 1'b0;
        timerTick = 1'b0;
        timerAutoReload = 1'b0;
        timerIrqClear = 1'b0;
        useAddrPins = 1'b0;
        txCommand = 1'b0;
        txBitStrobe = 1'b0;
        hostAddrPins = 6'h1c;
        addrLatch = 6'h15;
        probeBus = 8'h00;
        srcEn = 3'h0;
        error_cnt = 0;
        total_checks = 0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        s_regs();
        s_timer();
        s_page();
        s_test_one();
        s_flip();
        s_prbs();
        final_report();
    end
endmodule // tb_timer_reload_and_test_page_regs

`default_nettype wire

// file: verif/trp_checker.sv
// Checker: concurrent assertions on the register slice ports
`timescale 1ns/10ps
`default_nettype none

module trp_checker (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        timerIrqFlag,
    input wire logic        timerRunning,
    input wire logic [5:0]  addrLatch,
    input wire logic [5:0]  regAddress,
    input wire logic        samClock,
    input wire logic [7:0]  probeBus,
    input wire logic [4:0]  probeGroupSelect,
    input wire logic        serialSignalOutput,
    input wire logic [6:0]  parPortOut,
    input wire logic [6:0]  parPortOe,
    input wire logic        txCommand,
    input wire logic        prbsActive
);
    logic [7:0] pg_q, ts1_q, ts2_q;
    logic [2:0] quiet_q;
    wire  logic wrDone = psel && penable && pready && pwrite;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Shadow control registers; quiet_q lets registered outputs settle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pg_q    <= 8'h00;
            ts1_q   <= 8'h00;
            ts2_q   <= 8'h00;
            quiet_q <= 3'h0;
        end else begin
            quiet_q <= wrDone ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            if (wrDone && paddr == 8'hc0)
                pg_q <= pwdata[7:0];
            if (wrDone && paddr == 8'hc4)
                ts1_q <= pwdata[7:0];
            if (wrDone && paddr == 8'hc8)
                ts2_q <= pwdata[7:0];
        end
    end

    sequence settled;
        quiet_q == 3'h7;
    endsequence
    sequence cmdSeen;
        txCommand && ts2_q[6:5] != 2'h0;
    endsequence

    AST_PAGE_ON: assert property (
        settled ##0 pg_q[7] |-> regAddress[5:4] == pg_q[1:0])
        else $error("paged address bits wrong");
    AST_PAGE_OFF: assert property (
        settled ##0 !pg_q[7] |-> regAddress == addrLatch)
        else $error("unpaged address differs from latch");
    AST_SAM_OFF: assert property (
        settled ##0 ts1_q[5:4] == 2'h0 |-> !samClock)
        else $error("secure clock runs while switched off");
    AST_PIN_OE: assert property (
        settled |-> parPortOe[1] == (ts1_q[3] || ts2_q[7]))
        else $error("line one enable wrong");
    AST_SERIAL_SIGNAL_OUTPUT: assert property (
        settled ##0 $stable(probeBus)
        |-> serialSignalOutput == probeBus[ts1_q[2:0]])
        else $error("signal output bit wrong");
    AST_FLIP: assert property (
        settled ##0 ts2_q[7] && !ts1_q[3] && $stable(probeBus)
        |-> parPortOe == 7'h7f && parPortOut == {probeBus[3], probeBus[4],
        probeBus[0], probeBus[1], probeBus[2], probeBus[6], probeBus[5]})
        else $error("flipped port order wrong");
    AST_PRBS_IDLE: assert property (
        settled ##0 ts2_q[6:5] == 2'h0 |-> !prbsActive)
        else $error("sequence active with both modes off");
    AST_PRBS_GO: assert property (
        cmdSeen |=> prbsActive)
        else $error("sequence did not start on command");
    AST_PRBS_HOLD: assert property (
        !prbsActive && !txCommand |=> !prbsActive)
        else $error("sequence started without command");
    AST_GROUP: assert property (
        settled |-> probeGroupSelect == ts2_q[4:0])
        else $error("probe group select wrong");
    AST_IRQ_STOP: assert property (
        $rose(timerIrqFlag) |-> !timerRunning)
        else $error("timer still running when flag set");
endmodule // trp_checker

bind trp_top trp_checker u_chk (.*);

`default_nettype wire

// file: verif/trp_host_model.sv
// Host microcontroller model: APB master for the register slice
`timescale 1ns/10ps
`default_nettype none

module trp_host_model (
    input  wire logic        clock,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    // Bus idle until the first transfer
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // One transfer; request held until pready seen, idle edge after it
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic err, output logic tmo);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        tmo = (n >= 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
endmodule // trp_host_model

`default_nettype wire
